/* File: rtl/tw_host.sv */
`timescale 1ns/100ps
// Summary of operation
// - First byte after every START is the device address byte.
// - Write frame: address with write bit, register byte, then data bytes.
// - Read starts with a write frame holding only the register byte.
// - Second frame sends address with read bit; first byte is that register.
// - Fast-mode protocol, link clock never above 5 MHz.
// - Master drives the clock push-pull always; no stretching.
// - Master drives the data line high while the link is idle.
// - Inside a frame the data line is driven only while clock is low.
// - Each party owns its own data output enable; never two drivers.
// - Exactly one master and one device; no arbitration.
// - Bytes go MSB first, each followed by an acknowledge bit, low except after the last read byte.
// - Master withholds acknowledge on the last read byte, then STOP.

// Write data buffer between the user and the link sequencer
module tw_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         mclk,      // System clock
  input  wire logic         rst,       // Synchronous reset
  input  wire logic         in_valid,  // Producer has a word
  output logic              in_ready,  // Room for a word
  input  wire logic [W-1:0] in_data,   // Word written
  output logic              out_valid, // Word available
  input  wire logic         out_ready, // Consumer takes the word
  output logic      [W-1:0] out_data   // Oldest word
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wr_ptr_q;
  logic [AW:0]  rd_ptr_q;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("tw_fifo DEPTH must be a power of two, at least 2");
  end

  // Full when pointers differ only in the wrap bit
  assign in_ready  = !((wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]));
  assign out_valid = (wr_ptr_q != rd_ptr_q);
  assign out_data  = mem_q[rd_ptr_q[AW-1:0]];

  // Storage array
  always_ff @(posedge mclk) begin
    if (in_valid && in_ready) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end
endmodule

// Master for the point-to-point two-wire register port
module tw_host import tw_pkg::*; #(
  parameter int LEN_W      = 8,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic             mclk,         // System clock, 125 MHz
  input  wire logic             rst,          // Synchronous reset, active high
  input  wire logic             cmd_valid,    // Command offered
  output logic                  cmd_ready,    // Sequencer idle, command taken
  input  wire logic             cmd_read,     // 1 read, 0 write
  input  wire logic [7:0]       cmd_reg,      // Register address
  input  wire logic [LEN_W-1:0] cmd_len,      // Data byte count
  input  wire logic             addr_use_pin, // Low address bits from pin
  input  wire logic             addr_pin,     // Pin-selected low address bit
  input  wire logic [1:0]       addr_cfg,     // Configured low address bits
  input  wire logic             wr_valid,     // Write byte offered
  output logic                  wr_ready,     // Buffer has room
  input  wire logic [7:0]       wr_data,      // Write byte
  output logic                  rd_valid,     // Read byte pulse
  output logic      [7:0]       rd_data,      // Read byte
  output logic                  done,         // Command finished pulse
  output logic                  nack,         // Last command got no acknowledge
  output logic                  busy,         // Command in progress
  output logic                  scl_o,        // Link clock, push-pull
  input  wire logic             sda_i,        // Data line level
  output logic                  sda_o,        // Data line drive value
  output logic                  sda_oe        // Data line drive enable
);
  localparam logic [7:0] PH_LAST = 8'(PHASE_CYC - 1);

  if (4 * PHASE_CYC * CLK_NS < SCL_MIN_PER_NS || PHASE_CYC > 256) begin : g_chk
    $error("tw_host phase timing outside link limits");
  end
  if (LEN_W < 1) begin : g_chk_len
    $error("tw_host LEN_W must be at least 1");
  end

  tw_state_e        state_q;
  logic [7:0]       div_q;
  logic [1:0]       phase_q;
  logic [1:0]       step_q;
  logic [3:0]       bit_q;
  logic [7:0]       sh_q;
  logic [LEN_W-1:0] rem_q;
  logic [7:0]       reg_q;
  logic [6:0]       dev_q;
  logic             read_q;
  logic             rd_frame_q;
  logic             tx_q;
  logic             tick;
  logic             last_ph;
  logic             fifo_valid;
  logic             fifo_ready;
  logic [7:0]       fifo_data;

  // Device address from fixed high bits and selectable low bits
  function automatic logic [6:0] dev_addr(input logic use_pin, input logic pin,
                                          input logic [1:0] cfg);
    dev_addr = {DEV_ADDR_HI, (use_pin ? {1'b0, pin} : cfg)};
  endfunction

  tw_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );

  assign tick      = (div_q == PH_LAST);
  assign last_ph   = tick && (phase_q == 2'h3);
  assign cmd_ready = (state_q == ST_IDLE);
  assign busy      = (state_q != ST_IDLE);
  // Pop a write byte only when a data slot is due; empty buffer stalls the link
  assign fifo_ready = (state_q == ST_NEXT) && (step_q == STEP_DATA) && !rd_frame_q
                      && !read_q && (rem_q != '0);

  // Quarter-bit divider, restarted whenever the clock is parked low or idle
  always_ff @(posedge mclk) begin
    if (rst || state_q == ST_IDLE || state_q == ST_NEXT || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // Quarter-bit phase within the current bit
  always_ff @(posedge mclk) begin
    if (rst || state_q == ST_IDLE || state_q == ST_NEXT) begin
      phase_q <= '0;
    end else if (tick) begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // Frame sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q    <= ST_IDLE;
      step_q     <= STEP_ADDR;
      bit_q      <= '0;
      sh_q       <= '0;
      rem_q      <= '0;
      reg_q      <= '0;
      dev_q      <= '0;
      read_q     <= 1'b0;
      rd_frame_q <= 1'b0;
      tx_q       <= 1'b0;
      nack       <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cmd_valid) begin
            reg_q      <= cmd_reg;
            rem_q      <= cmd_len;
            read_q     <= cmd_read;
            dev_q      <= dev_addr(addr_use_pin, addr_pin, addr_cfg);
            rd_frame_q <= 1'b0;
            step_q     <= STEP_ADDR;
            nack       <= 1'b0;
            state_q    <= ST_START;
          end
        end
        ST_START: begin
          if (last_ph) begin
            state_q <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          bit_q <= '0;
          if (step_q == STEP_ADDR) begin
            sh_q    <= {dev_q, (rd_frame_q ? RW_READ : RW_WRITE)};
            tx_q    <= 1'b1;
            step_q  <= rd_frame_q ? STEP_DATA : STEP_REG;
            state_q <= ST_BITS;
          end else if (step_q == STEP_REG) begin
            sh_q    <= reg_q;
            tx_q    <= 1'b1;
            step_q  <= STEP_DATA;
            state_q <= ST_BITS;
          end else if (rem_q == '0 || (read_q && !rd_frame_q)) begin
            state_q <= ST_STOP;
          end else if (rd_frame_q) begin
            rem_q   <= rem_q - 1'b1;
            tx_q    <= 1'b0;
            state_q <= ST_BITS;
          end else if (fifo_valid) begin
            sh_q    <= fifo_data;
            rem_q   <= rem_q - 1'b1;
            tx_q    <= 1'b1;
            state_q <= ST_BITS;
          end
        end
        ST_BITS: begin
          // Capture mid-high; data bits shift in MSB first, the acknowledge bit is not shifted in
          if (tick && phase_q == 2'h2 && bit_q != ACK_BIT) begin
            sh_q <= {sh_q[6:0], sda_i};
          end
          if (last_ph) begin
            if (bit_q != ACK_BIT) begin
              bit_q <= bit_q + 4'h1;
            end else if (tx_q && sda_i) begin
              nack    <= 1'b1;
              state_q <= ST_STOP;
            end else begin
              state_q <= ST_NEXT;
            end
          end
        end
        ST_STOP: begin
          if (last_ph) begin
            state_q <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (last_ph) begin
            if (read_q && !rd_frame_q && !nack) begin
              rd_frame_q <= 1'b1;
              step_q     <= STEP_ADDR;
              state_q    <= ST_START;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Read byte and completion pulses
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
      done     <= 1'b0;
    end else begin
      rd_valid <= (state_q == ST_BITS) && last_ph && (bit_q == ACK_BIT) && !tx_q;
      if ((state_q == ST_BITS) && last_ph && (bit_q == ACK_BIT) && !tx_q) begin
        rd_data <= sh_q;
      end
      done <= (state_q == ST_GAP) && last_ph && !(read_q && !rd_frame_q && !nack);
    end
  end

  // Link pins; the clock is always driven and never waits on the device
  always_ff @(posedge mclk) begin
    if (rst) begin
      scl_o  <= 1'b1;
      sda_o  <= 1'b1;
      sda_oe <= 1'b1;
    end else begin
      case (state_q)
        ST_IDLE, ST_GAP: begin
          scl_o  <= 1'b1;
          sda_o  <= 1'b1;
          sda_oe <= 1'b1;
        end
        ST_START: begin
          scl_o  <= 1'b1;
          sda_o  <= (phase_q < 2'h2);
          sda_oe <= 1'b1;
        end
        ST_NEXT: begin
          scl_o  <= 1'b0;
          sda_o  <= 1'b0;
          sda_oe <= 1'b0;
        end
        ST_BITS: begin
          scl_o <= (phase_q >= 2'h2);
          if (phase_q >= 2'h2) begin
            sda_o  <= 1'b0;
            sda_oe <= 1'b0;
          end else if (bit_q != ACK_BIT) begin
            sda_o  <= sh_q[7];
            sda_oe <= tx_q;
          end else begin
            sda_o  <= (rem_q == '0);
            sda_oe <= !tx_q;
          end
        end
        ST_STOP: begin
          scl_o  <= (phase_q >= 2'h2);
          sda_o  <= 1'b0;
          sda_oe <= 1'b1;
        end
        default: begin
          scl_o  <= 1'b1;
          sda_o  <= 1'b1;
          sda_oe <= 1'b1;
        end
      endcase
    end
  end
endmodule

/* File: rtl/tw_pkg.sv */
package tw_pkg;

  // Fixed upper five bits of the device bus address
  localparam logic [4:0] DEV_ADDR_HI = 5'h0A;
  // Read/write bit values in the address byte
  localparam logic RW_WRITE = 1'h0;
  localparam logic RW_READ  = 1'h1;

  // System clock period and link timing in ns
  localparam int CLK_NS         = 8;
  localparam int SCL_MIN_PER_NS = 200;  // 5 MHz ceiling on the link clock
  localparam int PHASE_NS       = 50;   // Quarter of one link bit
  localparam int TBUF_NS        = 200;  // Idle gap between STOP and START
  // Cycles per quarter bit, rounded up so every least time holds
  localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;

  // Byte steps inside a frame
  localparam logic [1:0] STEP_ADDR = 2'h0;
  localparam logic [1:0] STEP_REG  = 2'h1;
  localparam logic [1:0] STEP_DATA = 2'h2;

  // Bit index of the acknowledge slot
  localparam logic [3:0] ACK_BIT = 4'h8;

  // Link sequencer states, one bit apart along the usual path except NEXT to STOP and GAP to IDLE or START
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_NEXT  = 3'h3,
    ST_BITS  = 3'h2,
    ST_STOP  = 3'h6,
    ST_GAP   = 3'h7
  } tw_state_e;

endpackage

/* File: tb/tw_host_sva.sv */
`timescale 1ns/100ps
module tw_host_sva (
  input wire logic mclk,      // Clock
  input wire logic rst,       // Reset
  input wire logic cmd_valid, // Offered
  input wire logic cmd_ready, // Idle
  input wire logic done,      // Ended
  input wire logic nack,      // No ack
  input wire logic wr_ready,  // Room
  input wire logic scl_o,     // Link clock
  input wire logic sda_o,     // Data value
  input wire logic sda_oe     // Data enable
);
  localparam int HALF_MIN = 13; // 100 ns
  localparam int FREE_MIN = 25; // 200 ns
  logic       scl_q;
  logic [7:0] lvl_q;
  logic [7:0] free_q;

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // Length of the clock level and of the idle bus
  always_ff @(posedge mclk) begin
    if (rst) begin
      scl_q  <= 1'b1;
      lvl_q  <= 8'hFF;
      free_q <= 8'hFF;
    end else begin
      scl_q  <= scl_o;
      lvl_q  <= (scl_o != scl_q) ? 8'h01 : lvl_q + {7'h00, lvl_q != 8'hFF};
      free_q <= !(scl_o && sda_o) ? 8'h00 : free_q + {7'h00, free_q != 8'hFF};
    end
  end

  AST_IDLE_HIGH: assert property (cmd_ready |-> scl_o && sda_o && sda_oe)
    else $error("idle link not high");
  AST_HIGH_MIN: assert property ($fell(scl_o) |-> lvl_q >= HALF_MIN)
    else $error("clock high too short");
  AST_LOW_MIN: assert property ($rose(scl_o) |-> lvl_q >= HALF_MIN)
    else $error("clock low too short");
  AST_RELEASE: assert property ($rose(scl_o) && !sda_oe |-> !sda_oe [*8])
    else $error("data driven with clock high");
  AST_START_HOLD: assert property (
    $fell(sda_o) && scl_o && sda_oe |-> scl_o [*8] ##[1:12] !scl_o)
    else $error("start hold wrong");
  AST_STOP_SETUP: assert property (
    $rose(sda_o) && scl_o && sda_oe && $past(sda_oe) |-> $past(scl_o, 8))
    else $error("stop setup too short");
  AST_BUS_FREE: assert property ($fell(sda_o) && scl_o && sda_oe |-> free_q >= FREE_MIN)
    else $error("bus free time too short");
  AST_NACK_KEEP: assert property ($fell(nack) |-> $past(cmd_valid) && $past(cmd_ready))
    else $error("nack cleared early");

  cover property ($rose(nack));
  cover property (done && !nack);
  cover property (!wr_ready);
endmodule

bind tw_host tw_host_sva u_sva (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .done(done), .nack(nack), .wr_ready(wr_ready), .scl_o(scl_o),
  .sda_o(sda_o), .sda_oe(sda_oe));

/* File: tb/tw_dev_model.sv */
`timescale 1ns/100ps
// One device on a point-to-point link, no arbitration
// Same register behaviour serves the secure-module port too
module tw_dev_model #(
  parameter logic [7:0] FIFO_REG = 8'h05 // FIFO address, plain default
) (
  input  wire logic       mclk, // Clock
  input  wire logic       rst,  // Reset
  input  wire logic       scl,  // Input only, never stretched
  input  wire logic       h_oe, // Host enable
  input  wire logic       h_o,  // Host value
  input  wire logic [1:0] low,  // Address bits
  output logic            line  // Data line
);
  logic [7:0] mem [256];
  logic [7:0] fq [$];
  logic [7:0] sh, sb, ptr, ob, bn;
  logic [3:0] cnt;
  logic       scl_q, keep_q, act, hit, rd, tx, mack, d_oe, d_o;

  // Device drives only while the link clock is low
  wire dev_drv = d_oe && !scl;
  // Two drivers give unknown; keeper holds the line
  assign line = (h_oe && dev_drv) ? 1'bx : h_oe ? h_o : dev_drv ? d_o : keep_q;

  // Frame tracking at the link clock edges
  always @(posedge mclk) begin
    scl_q  <= scl;
    keep_q <= line;
    if (rst) begin
      act  <= 1'b0;
      d_oe <= 1'b0;
    end else if (scl && scl_q && keep_q && !line) begin
      act <= 1'b1;
      cnt <= 4'h0;
      bn  <= 8'h00;
      tx  <= 1'b0;
    end else if (scl && scl_q && !keep_q && line) begin
      act <= 1'b0;
    end else if (act && scl && !scl_q) begin
      d_oe <= 1'b0;
      sh   <= {sh[6:0], line};
      mack <= line;
    end else if (act && !scl && scl_q) begin
      cnt  <= cnt + 4'h1;
      d_oe <= tx;
      d_o  <= sb[7];
      sb   <= {sb[6:0], 1'b0};
      if (cnt == 4'h8) begin
        tx   <= 1'b0;
        d_o  <= 1'b0;
        d_oe <= (bn == 8'h00) ? (sh[7:1] == {5'b01010, low}) : (hit && !rd);
        if (bn == 8'h00) hit <= sh[7:1] == {5'b01010, low};
        if (bn == 8'h00) rd <= sh[0];
        if (bn == 8'h01 && hit && !rd) ptr <= sh;
        if (bn > 8'h01 && hit && !rd) begin
          if (ptr == FIFO_REG) fq.push_back(sh);
          else mem[ptr] <= sh;
          if (ptr != FIFO_REG) ptr <= ptr + 8'h01;
        end
      end
      if (cnt == 4'h9) begin
        cnt <= 4'h1;
        bn  <= bn + 8'h01;
        if (hit && rd && (bn == 8'h00 || !mack)) begin
          if (ptr == FIFO_REG) ob = fq.pop_front();
          else ob = mem[ptr];
          if (ptr != FIFO_REG) ptr <= ptr + 8'h01;
          tx   <= 1'b1;
          d_oe <= 1'b1;
          d_o  <= ob[7];
          sb   <= {ob[6:0], 1'b0};
        end
      end
    end
  end
endmodule

/* File: tb/tw_host_test.sv */
`timescale 1ns/100ps
module tw_host_test;
  typedef struct packed {
    logic rd; logic [7:0] rg; logic [7:0] len; logic up;
    logic pin; logic [1:0] cfg; logic nk; logic [7:0] base;
  } tw_row_s;
  logic       mclk, rst, cmd_valid, cmd_ready, cmd_read, addr_use_pin, addr_pin;
  logic       wr_valid, wr_ready, rd_valid, done, nack, busy, scl_o, sda, sda_o, sda_oe;
  logic [7:0] cmd_reg, cmd_len, wr_data, rd_data;
  logic [1:0] addr_cfg;
  int         errors, checks_done;
  tw_row_s    rows [7] = '{'{0, 8'h10, 3, 0, 0, 1, 0, 8'hA0}, '{1, 8'h10, 3, 0, 0, 1, 0, 8'hA0},
    '{0, 8'h05, 2, 0, 0, 1, 0, 8'h50}, '{1, 8'h05, 2, 0, 0, 1, 0, 8'h50},
    '{1, 8'h11, 2, 1, 1, 0, 0, 8'hA1}, '{1, 8'h10, 1, 1, 0, 1, 1, 8'h00},
    '{1, 8'h12, 1, 0, 0, 3, 1, 8'h00}};

  tw_host dut (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_read(cmd_read), .cmd_reg(cmd_reg), .cmd_len(cmd_len), .addr_use_pin(addr_use_pin),
    .addr_pin(addr_pin), .addr_cfg(addr_cfg), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack(nack),
    .busy(busy), .scl_o(scl_o), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  tw_dev_model dev (.mclk(mclk), .rst(rst), .scl(scl_o), .h_oe(sda_oe), .h_o(sda_o),
    .low(2'h1), .line(sda));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic push(input logic [7:0] d);
    @(negedge mclk);
    wr_valid = 1'b1;
    wr_data = d;
    while (wr_ready !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    wr_valid = 1'b0;
  endtask

  task automatic run(input tw_row_s r);
    int k;
    int n;
    k = 0;
    n = 0;
    @(negedge mclk);
    {cmd_valid, cmd_read, cmd_reg, cmd_len} = {1'b1, r.rd, r.rg, r.len};
    {addr_use_pin, addr_pin, addr_cfg} = {r.up, r.pin, r.cfg};
    while (cmd_ready !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    cmd_valid = 1'b0;
    chk("busy", 8'h01, {7'h00, busy});
    while (done !== 1'b1 && n < 20000) begin
      if (rd_valid === 1'b1) begin
        chk("read byte", 8'(r.base + k), rd_data);
        k++;
      end
      @(negedge mclk);
      n++;
    end
    chk("done", 8'h01, {7'h00, done});
    chk("byte count", (r.rd && !r.nk) ? r.len : 8'h00, 8'(k));
    chk("nack", {7'h00, r.nk}, {7'h00, nack});
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (90000) @(posedge mclk);
    errors++;
    $display("unexpected watchdog expiry");
    complete_run();
  end

  // Main sequence
  initial begin
    {rst, cmd_valid, cmd_read, addr_use_pin, addr_pin, wr_valid} = 6'h20;
    {cmd_reg, cmd_len, wr_data, addr_cfg} = 26'h0;
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    foreach (rows[i]) begin
      if (!rows[i].rd) for (int j = 0; j < rows[i].len; j++) push(8'(rows[i].base + j));
      run(rows[i]);
      $display("row %0d done", i);
    end
    for (int j = 0; j < 8; j++) push(8'(8'h30 + j));
    chk("full buffer ready", 8'h00, {7'h00, wr_ready});
    run('{0, 8'h20, 8, 0, 0, 1, 0, 8'h30});
    chk("drained buffer ready", 8'h01, {7'h00, wr_ready});
    run('{1, 8'h20, 8, 0, 0, 1, 0, 8'h30});
    run('{1, 8'h20, 1, 0, 0, 2, 1, 8'h00});
    run('{0, 8'h30, 0, 0, 0, 1, 0, 8'h00});
    $display("burst test done");
    // Reset in the middle of a read, then the link must work again
    @(negedge mclk);
    {cmd_valid, cmd_read, cmd_reg, cmd_len} = {1'b1, 1'b1, 8'h10, 8'h03};
    {addr_use_pin, addr_cfg} = {1'b0, 2'h1};
    @(negedge mclk);
    cmd_valid = 1'b0;
    repeat (1500) @(negedge mclk);
    rst = 1'b1;
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    chk("idle after reset", 8'h1E, {3'h0, scl_o, sda_o, sda_oe, cmd_ready, nack});
    chk("busy after reset", 8'h00, {7'h00, busy});
    run(rows[1]);
    $display("reset test done");
    complete_run();
  end
endmodule
